//--- logic/bmod_top.sv
// bmod_top.sv: strap capture, boot sequencing and overlay address mapping.
// assumes a single 100 MHz clock; strap and flag pins are asynchronous.
`timescale 1ns/10ps
`include "bmod_cfg.svh"

// Notes on behaviour
// [R1] memory mode comes from strap bit C sampled while reset is low
// [R2] strap C pin doubles as flag two after reset
// [R3] external strap driver releases the shared pin after reset
// [R4] 000: full memory mode, byte DMA loads 32 words, execution held
// [R5] 010: no boot, full memory mode, start at external address zero
// [R6] no boot: byte DMA usable by software, never started or awaited
// [R7] C=1, B=0, A=0: host mode, byte DMA loads 32 words, execution held
// [R8] C=1, A=1, B=0: host mode, hold until host writes program address zero
// [R9] host mode, D=0: acknowledge driven both ways, no wire-OR
// [R10] host mode, D=1: acknowledge open drain, external pullup, wire-OR allowed
// [R11] full mode: 24-bit program memory, 48K internal, two 8K external overlays
// [R12] host mode: overlay addressing uses one line, no external execution
// [R13] program window values 0,4,5,6,7 select internal memory
// [R14] program values 1,2 select external overlays, A13 low or high
// [R15] data window values 0,4,5,6,7,8 select internal memory
// [R16] data values 1,2 select external overlays, A13 0 or 1
// [R17] data memory 16 bits, 56K internal, 32 control registers included
// [R18] internal data accesses finish in one cycle
// [R19] external data accesses add the programmed wait states
// [R20] reset empties stacks, masks interrupts, clears mode status, then boots
// [R21] straps latched at reset release, held until next reset
// [R22] unlisted strap combinations are flagged as unsupported
module bmod_top
	import bmod_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// strap pins
	input  wire logic [3:0]  strap_i,
	// shared flag pin, three pad signals and three core signals
	input  wire logic        shared_flag_pin_i,
	output logic             shared_flag_pin_o,
	output logic             shared_flag_pin_oe_o,
	input  wire logic        flag_out_i,
	input  wire logic        flag_dir_out_i,
	output logic             flag_in_o,
	// boot progress
	input  wire logic        bus_req_i,
	input  wire logic        byte_mem_dma_word_i,
	input  wire logic        host_port_dma_pm0_wr_i,
	input  wire logic        sw_byte_mem_dma_start_i,
	output logic             byte_mem_dma_start_o,
	output logic             byte_mem_dma_avail_o,
	output logic             core_hold_o,
	output logic             core_ext_exec_o,
	output logic [13:0]      core_start_pc_o,
	output logic             core_reset_ctx_o,
	output logic [6:0]       mode_status_reg_o,
	// mode status
	output logic             host_mode_o,
	output logic             unsupported_o,
	// host acknowledge pin
	input  wire logic        host_busy_i,
	output logic             host_ack_out_o,
	output logic             host_ack_out_oe_o,
	// overlay windows
	input  wire logic [3:0]  prog_window_sel_i,
	input  wire logic [3:0]  data_window_sel_i,
	input  wire logic [13:0] prog_addr_i,
	input  wire logic [13:0] data_addr_i,
	input  wire logic        data_req_i,
	input  wire logic [3:0]  data_wait_count_i,
	input  wire logic        wait_mode_i,
	output bmod_ovl_type     prog_ovl_o,
	output bmod_ovl_type     data_ovl_o,
	output logic             host_a0_o,
	output logic             data_ready_o
);

	logic [2:0]     flag_sync_reg;
	logic [3:0]     strap_s1_reg;
	logic [3:0]     strap_s2_reg;
	logic [3:0]     strap_s3_reg;
	logic [3:0]     strap_hold_reg;
	logic           rst_seen_reg;
	bmod_mode_type  mode_reg;
	bmod_mode_type  mode_next;
	bmod_state_type state_reg;
	bmod_state_type state_next;
	logic [5:0]     boot_cnt_reg;
	logic [4:0]     wait_cnt_reg;
	logic [4:0]     wait_target;
	logic           data_ext;
	logic           data_sel_ext;
	logic           data_sel_a13;
	logic           prog_sel_ext;
	logic           prog_sel_a13;
	logic           prog_ext;
	logic           byte_start_next;

	// strap pins are asynchronous: three stages, accept when last two agree
	always_ff @(posedge clk_i) begin
		strap_s1_reg <= strap_i;
		strap_s2_reg <= strap_s1_reg;
		strap_s3_reg <= strap_s2_reg;
	end

	// track level while reset is low; last agreed value wins
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			if (strap_s2_reg == strap_s3_reg)
				strap_hold_reg <= strap_s3_reg; // R1
		end
	end

	// decode of the held straps
	always_comb begin
		mode_next = '0;
		mode_next.host_mode = strap_hold_reg[2]; // R1
		mode_next.ack_open_drain = strap_hold_reg[3] & strap_hold_reg[2]; // R9 R10
		casez (strap_hold_reg)
			4'b?000: mode_next.boot = 2'(BMOD_BOOT_BYTE_DMA); // R4
			4'b?010: mode_next.boot = 2'(BMOD_BOOT_NONE); // R5
			4'b?100: mode_next.boot = 2'(BMOD_BOOT_BYTE_DMA); // R7
			4'b?101: mode_next.boot = 2'(BMOD_BOOT_HOST_DMA); // R8
			default: begin
				mode_next.boot = 2'(BMOD_BOOT_BAD);
				mode_next.unsupported = 1'b1; // R22
			end
		endcase
	end

	// latch once at the first clock after reset release
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rst_seen_reg <= 1'b0;
			mode_reg     <= '0;
		end else if (!rst_seen_reg) begin
			rst_seen_reg <= 1'b1;
			mode_reg     <= mode_next; // R21
		end
	end

	// flag side of the shared pin; never driven during reset so a strap driver can own it
	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			flag_sync_reg <= 3'h0;
		else
			flag_sync_reg <= {flag_sync_reg[1:0], shared_flag_pin_i};
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			flag_in_o <= 1'b0;
		else if (flag_sync_reg[1] == flag_sync_reg[2])
			flag_in_o <= flag_sync_reg[2]; // R2
	end

	assign shared_flag_pin_o    = flag_out_i;
	assign shared_flag_pin_oe_o = rst_b_i & rst_seen_reg & flag_dir_out_i; // R2 R3

	// boot sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			BMOD_ST_RESET:
				state_next = BMOD_ST_WAIT_BUS;
			BMOD_ST_WAIT_BUS: begin
				if (!bus_req_i) begin // R20
					if (mode_reg.unsupported)
						state_next = BMOD_ST_HALT; // R22
					else if (mode_reg.boot == 2'(BMOD_BOOT_BYTE_DMA))
						state_next = BMOD_ST_BYTE_LOAD; // R4 R7
					else if (mode_reg.boot == 2'(BMOD_BOOT_HOST_DMA))
						state_next = BMOD_ST_HOST_LOAD; // R8
					else
						state_next = BMOD_ST_RUN; // R5 R6
				end
			end
			BMOD_ST_BYTE_LOAD:
				if (byte_mem_dma_word_i && boot_cnt_reg == `BMOD_BOOT_WORDS - 6'd1)
					state_next = BMOD_ST_RUN; // R4 R7
			BMOD_ST_HOST_LOAD:
				if (host_port_dma_pm0_wr_i)
					state_next = BMOD_ST_RUN; // R8
			BMOD_ST_RUN:
				state_next = BMOD_ST_RUN;
			BMOD_ST_HALT:
				state_next = BMOD_ST_HALT;
			default:
				state_next = BMOD_ST_HALT;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			state_reg <= BMOD_ST_RESET;
		else if (rst_seen_reg)
			state_reg <= state_next;
	end

	// count words of the automatic byte load
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || state_reg != BMOD_ST_BYTE_LOAD)
			boot_cnt_reg <= 6'd0;
		else if (byte_mem_dma_word_i)
			boot_cnt_reg <= boot_cnt_reg + 6'd1; // R4 R7
	end

	// one-cycle start pulse: automatic on entry to load, or software request when running in full memory mode
	always_comb begin
		byte_start_next = 1'b0;
		if (state_reg == BMOD_ST_WAIT_BUS && state_next == BMOD_ST_BYTE_LOAD)
			byte_start_next = 1'b1; // R4 R7
		else if (state_reg == BMOD_ST_RUN && sw_byte_mem_dma_start_i && !mode_reg.host_mode)
			byte_start_next = 1'b1; // R6
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			byte_mem_dma_start_o <= 1'b0;
		else
			byte_mem_dma_start_o <= byte_start_next; // R6
	end

	assign byte_mem_dma_avail_o = (state_reg == BMOD_ST_RUN) && !mode_reg.host_mode; // R6
	assign core_hold_o      = (state_reg != BMOD_ST_RUN); // R4 R7 R8 R22
	assign core_reset_ctx_o = (state_reg == BMOD_ST_RESET) || !rst_b_i; // R20
	assign mode_status_reg_o = `BMOD_MODE_STATUS_REG_RESET; // R20
	// external execution only with no boot; host mode has a 16-bit bus
	always_comb begin
		core_ext_exec_o = 1'b0;
		if (mode_reg.unsupported)
			core_ext_exec_o = 1'b0; // R22
		else if (mode_reg.host_mode)
			core_ext_exec_o = 1'b0; // R12
		else if (mode_reg.boot == 2'(BMOD_BOOT_NONE))
			core_ext_exec_o = 1'b1; // R5
	end
	assign core_start_pc_o  = `BMOD_BOOT_PC; // R5 R8
	assign host_mode_o      = mode_reg.host_mode;
	assign unsupported_o    = mode_reg.unsupported; // R22

	// acknowledge pin: low means ready; open drain only pulls low
	always_comb begin
		host_ack_out_o    = 1'b0;
		host_ack_out_oe_o = 1'b0;
		if (mode_reg.host_mode && rst_seen_reg) begin
			if (mode_reg.ack_open_drain) begin
				host_ack_out_oe_o = !host_busy_i; // R10
			end else begin
				host_ack_out_o    = host_busy_i;
				host_ack_out_oe_o = 1'b1; // R9
			end
		end
	end

	// selector decode: only the two overlay codes leave the chip, all others stay inside
	always_comb begin
		prog_sel_ext = 1'b0;
		prog_sel_a13 = 1'b0;
		case (prog_window_sel_i)
			`BMOD_PSEL_EXT1: begin
				prog_sel_ext = 1'b1; // R14
				prog_sel_a13 = 1'b0; // R14
			end
			`BMOD_PSEL_EXT2: begin
				prog_sel_ext = 1'b1; // R14
				prog_sel_a13 = 1'b1; // R14
			end
			default: begin
				prog_sel_ext = 1'b0; // R13
				prog_sel_a13 = 1'b0;
			end
		endcase
	end

	always_comb begin
		data_sel_ext = 1'b0;
		data_sel_a13 = 1'b0;
		case (data_window_sel_i)
			`BMOD_DSEL_EXT1: begin
				data_sel_ext = 1'b1; // R16
				data_sel_a13 = 1'b0; // R16
			end
			`BMOD_DSEL_EXT2: begin
				data_sel_ext = 1'b1; // R16
				data_sel_a13 = 1'b1; // R16
			end
			default: begin
				data_sel_ext = 1'b0; // R15
				data_sel_a13 = 1'b0;
			end
		endcase
	end

	// overlay mapping; window range 0x2000-0x3FFF
	assign prog_ext = prog_sel_ext
		&& prog_addr_i >= `BMOD_OVL_BASE && prog_addr_i <= `BMOD_OVL_LAST; // R11 R14

	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			prog_ovl_o <= '0;
		else begin
			prog_ovl_o.ext <= prog_ext; // R11 R13 R14
			prog_ovl_o.a13 <= prog_sel_a13; // R14
			prog_ovl_o.low <= prog_addr_i[12:0]; // R14
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			data_ovl_o <= '0;
		else begin
			data_ovl_o.ext <= data_ext; // R15 R16
			data_ovl_o.a13 <= data_sel_a13; // R16
			data_ovl_o.low <= data_addr_i[12:0]; // R16
		end
	end

	// host mode has one address line: data overlay number goes out on A0
	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			host_a0_o <= 1'b0;
		else
			host_a0_o <= mode_reg.host_mode & data_sel_a13; // R12
	end

	assign data_ext = data_sel_ext
		&& data_addr_i >= `BMOD_OVL_BASE && data_addr_i <= `BMOD_OVL_LAST; // R16

	// wait mode doubles the count (plus one); five bits hold the largest target
	always_comb begin
		if (wait_mode_i)
			wait_target = {data_wait_count_i, 1'b1}; // R19
		else
			wait_target = {1'b0, data_wait_count_i}; // R19
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || !data_req_i || !data_ext)
			wait_cnt_reg <= 5'd0;
		else if (wait_cnt_reg != wait_target)
			wait_cnt_reg <= wait_cnt_reg + 5'd1; // R19
	end

	// internal access ready at once; external after its wait states
	always_comb begin
		data_ready_o = 1'b0;
		if (data_req_i) begin
			if (!data_ext)
				data_ready_o = 1'b1; // R17 R18
			else if (wait_cnt_reg == wait_target)
				data_ready_o = 1'b1; // R19
		end
	end

endmodule : bmod_top

//--- logic/bmod_cfg.svh
// bmod_cfg.svh: constants for boot mode and overlay decode.
// assumes inclusion by the top module only.
`ifndef BMOD_CFG_SVH
`define BMOD_CFG_SVH
`define BMOD_BOOT_WORDS      6'd32
`define BMOD_OVL_BASE        14'h2000
`define BMOD_OVL_LAST        14'h3FFF
`define BMOD_OVL_A13_POS     13
`define BMOD_PSEL_EXT1       4'h1
`define BMOD_PSEL_EXT2       4'h2
`define BMOD_DSEL_EXT1       4'h1
`define BMOD_DSEL_EXT2       4'h2
`define BMOD_WAIT_MAX        4'hF
`define BMOD_MODE_STATUS_REG_RESET     7'h00
`define BMOD_PM_INT_WORDS    17'h0C000
`define BMOD_DM_INT_WORDS    17'h0E000
`define BMOD_DM_CTRL_REGS    6'd32
`define BMOD_BOOT_PC         14'h0000
`endif

//--- logic/bmod_pkg.sv
// bmod_pkg.sv: types shared by the boot mode and overlay decoder.
// assumes bmod_cfg.svh sits beside it.
package bmod_pkg;
	typedef enum logic [2:0] {
		BMOD_BOOT_BYTE_DMA,
		BMOD_BOOT_NONE,
		BMOD_BOOT_HOST_DMA,
		BMOD_BOOT_BAD
	} bmod_boot_type;

	typedef enum logic [2:0] {
		BMOD_ST_RESET,
		BMOD_ST_WAIT_BUS,
		BMOD_ST_BYTE_LOAD,
		BMOD_ST_HOST_LOAD,
		BMOD_ST_RUN,
		BMOD_ST_HALT
	} bmod_state_type;

	typedef struct packed {
		logic       host_mode;
		logic       ack_open_drain;
		logic       unsupported;
		logic [1:0] boot;
	} bmod_mode_type;

	typedef struct packed {
		logic        ext;
		logic        a13;
		logic [12:0] low;
	} bmod_ovl_type;
endpackage : bmod_pkg

//--- tb/bmod_props.sv
// bmod_props.sv: port assertions for the boot mode decoder.
// assumes a bind onto bmod_top, one clock.
`timescale 1ns/10ps
module bmod_props
	import bmod_pkg::*;
(
	// clock and reset
	input wire logic         clk_i,
	input wire logic         rst_b_i,
	// inputs
	input wire logic         host_busy_i,
	input wire logic [3:0]   prog_window_sel_i,
	input wire logic [3:0]   data_window_sel_i,
	input wire logic [13:0]  prog_addr_i,
	input wire logic [13:0]  data_addr_i,
	// outputs
	input wire logic         host_mode_o,
	input wire logic         unsupported_o,
	input wire logic         core_hold_o,
	input wire logic         host_ack_out_o,
	input wire logic         host_ack_out_oe_o,
	input wire logic [6:0]   mode_status_reg_o,
	input wire logic [13:0]  core_start_pc_o,
	input wire bmod_ovl_type prog_ovl_o,
	input wire bmod_ovl_type data_ovl_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// mode lands one edge after release, so wait three high samples
	sequence s_run; rst_b_i [*3]; endsequence
	sequence s_pext; prog_window_sel_i inside {4'h1, 4'h2} && prog_addr_i >= 14'h2000; endsequence
	sequence s_dext; data_window_sel_i inside {4'h1, 4'h2} && data_addr_i >= 14'h2000; endsequence
	a_mode_held: assert property (s_run |-> $stable(host_mode_o) && $stable(unsupported_o))
		else $error("mode moved");
	a_prog_int: assert property (prog_window_sel_i inside {4'h0, [4'h4:4'h7]} |=> !prog_ovl_o.ext)
		else $error("prog window not internal");
	a_prog_ext: assert property (s_pext |=> prog_ovl_o == {1'b1, $past(prog_window_sel_i) == 4'h2,
		$past(prog_addr_i[12:0])})
		else $error("prog overlay wrong");
	a_data_int: assert property (data_window_sel_i inside {4'h0, [4'h4:4'h8]} |=> !data_ovl_o.ext)
		else $error("data window not internal");
	a_data_ext: assert property (s_dext |=> data_ovl_o == {1'b1, $past(data_window_sel_i) == 4'h2,
		$past(data_addr_i[12:0])})
		else $error("data overlay wrong");
	a_ack_quiet: assert property (!host_mode_o |-> !host_ack_out_oe_o && !host_ack_out_o)
		else $error("ack active outside host mode");
	a_ack_host: assert property (host_mode_o |-> (host_ack_out_oe_o && host_ack_out_o == host_busy_i)
		|| (!host_ack_out_o && host_ack_out_oe_o == !host_busy_i))
		else $error("ack drive wrong");
	a_unsup_hold: assert property (unsupported_o |-> core_hold_o)
		else $error("unsupported straps ran");
	a_status_clear: assert property (mode_status_reg_o == 7'h00 && core_start_pc_o == 14'h0000)
		else $error("status or start address nonzero");
endmodule : bmod_props

bind bmod_top bmod_props u_props (.clk_i, .rst_b_i, .host_busy_i, .prog_window_sel_i, .data_window_sel_i,
	.prog_addr_i, .data_addr_i, .host_mode_o, .unsupported_o, .core_hold_o, .host_ack_out_o,
	.host_ack_out_oe_o, .mode_status_reg_o, .core_start_pc_o, .prog_ovl_o, .data_ovl_o);

//--- tb/bmod_strap_model.sv
// bmod_strap_model.sv: three-state strap driver on the mode pins.
// assumes the bench resolves the shared flag pin.
`timescale 1ns/10ps
module bmod_strap_model (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	// wanted strap level
	input  wire logic [3:0] val_i,
	// pins
	output logic [3:0]      strap_o = 4'h0,
	output logic            pin_o,
	output logic            pin_oe_o
);
	assign pin_oe_o = !rst_b_i;
	assign pin_o = strap_o[2];
	// released lines wander, so a late strap sample shows up
	always @(posedge clk_i) strap_o <= rst_b_i ? ~strap_o : val_i;
endmodule : bmod_strap_model

//--- tb/bmod_top_test.sv
// bmod_top_test.sv: self-checking bench for boot mode and overlay decode.
// assumes bmod_pkg and the strap model compiled first.
`timescale 1ns/10ps
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin errors++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, x); end end
module bmod_top_test;
	import bmod_pkg::*;
	typedef struct { int due; logic [1:0] k; logic [14:0] v; logic [14:0] m; } bmod_note_type;
	logic         clk_i = 1'h0, rst_b_i = 1'h0, pin_last = 1'h0, host_busy_i = 1'h0, flag_out_i = 1'h0;
	logic         byte_mem_dma_word_i = 1'h0, host_port_dma_pm0_wr_i = 1'h0, flag_dir_out_i = 1'h0;
	logic [3:0]   val = 4'h0, prog_window_sel_i = 4'h0, data_window_sel_i = 4'h0, strap_i, s, ps, ds;
	logic [13:0]  prog_addr_i = 14'h0000, data_addr_i = 14'h0000, pa, da;
	logic         shared_flag_pin_i, shared_flag_pin_o, shared_flag_pin_oe_o, byte_mem_dma_start_o, core_hold_o;
	logic         core_ext_exec_o, host_mode_o, unsupported_o, host_ack_out_o, host_ack_out_oe_o;
	logic         sm_oe, sm_pin, bad, nb, seen, b, pe, de, flag_in_o;
	logic [14:0]  o;
	bmod_ovl_type prog_ovl_o, data_ovl_o;
	int           errors = 0, compares = 0, cyc = 0;
	bmod_note_type q[$], n;
	logic [3:0]   modes[9] = '{4'h0, 4'h8, 4'h2, 4'h4, 4'h5, 4'hC, 4'hD, 4'h3, 4'hE};

	bmod_strap_model u_straps (.clk_i, .rst_b_i, .val_i(val), .strap_o(strap_i), .pin_o(sm_pin), .pin_oe_o(sm_oe));
	bmod_top DUT (.clk_i, .rst_b_i, .strap_i, .shared_flag_pin_i, .shared_flag_pin_o, .shared_flag_pin_oe_o,
		.flag_out_i, .flag_dir_out_i, .flag_in_o, .bus_req_i(1'h0), .byte_mem_dma_word_i,
		.host_port_dma_pm0_wr_i, .sw_byte_mem_dma_start_i(1'h0), .byte_mem_dma_start_o,
		.byte_mem_dma_avail_o(), .core_hold_o, .core_ext_exec_o, .core_start_pc_o(), .core_reset_ctx_o(),
		.mode_status_reg_o(), .host_mode_o, .unsupported_o, .host_busy_i, .host_ack_out_o, .host_ack_out_oe_o,
		.prog_window_sel_i, .data_window_sel_i, .prog_addr_i, .data_addr_i, .data_req_i(1'h0),
		.data_wait_count_i(4'h0), .wait_mode_i(1'h0), .prog_ovl_o, .data_ovl_o, .host_a0_o(), .data_ready_o());

	// undriven pin drifts rather than keeping its last level
	assign shared_flag_pin_i = sm_oe ? sm_pin : shared_flag_pin_oe_o ? shared_flag_pin_o : ~pin_last;
	initial forever #5 clk_i = ~clk_i;
	always @(posedge clk_i) pin_last <= shared_flag_pin_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			errors++;
			stop_test();
		end
	end
	always @(negedge clk_i) begin
		while (q.size() != 0 && q[0].due <= cyc) begin
			n = q.pop_front();
			o = n.k == 2'h0 ? prog_ovl_o : n.k == 2'h1 ? data_ovl_o :
				n.k == 2'h2 ? {13'h0000, host_ack_out_oe_o, host_ack_out_o} :
				{9'h000, shared_flag_pin_oe_o, flag_in_o, core_hold_o, host_mode_o, unsupported_o, core_ext_exec_o};
			`CHK(o & n.m, n.v)
		end
	end

	task automatic go(input int c);
		repeat (c) @(posedge clk_i);
	endtask : go
	task automatic note(input logic [1:0] k, input logic [14:0] v, input logic [14:0] m, input int d);
		q.push_back('{cyc + d, k, v & m, m});
	endtask : note
	task automatic stop_test;
		if (errors == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : stop_test

	initial begin
		void'($urandom(32'h144C));
		foreach (modes[i]) begin
			s = modes[i];
			bad = !(s[2:0] inside {3'h0, 3'h2, 3'h4, 3'h5});
			nb = s[2:0] == 3'h2;
			go(1);
			rst_b_i <= 1'h0;
			val <= s;
			go(20);
			rst_b_i <= 1'h1;
			go(3);
			note(2'h3, {~nb, s[2], bad, nb}, bad ? 15'h000A : 15'h000F, 2);
			if (s[2:0] inside {3'h0, 3'h4}) begin
				seen = 1'h0;
				repeat (8) begin
					@(negedge clk_i);
					seen |= byte_mem_dma_start_o;
				end
				`CHK(seen, 1'h1)
				@(posedge clk_i) byte_mem_dma_word_i <= 1'h1;
				go(30);
				note(2'h3, 15'h0008, 15'h0008, 2);
				go(2);
				byte_mem_dma_word_i <= 1'h0;
				go(1);
				note(2'h3, 15'h0000, 15'h0008, 2);
			end else if (s[2:0] == 3'h5) begin
				note(2'h3, 15'h0008, 15'h0008, 2);
				go(4);
				host_port_dma_pm0_wr_i <= 1'h1;
				go(1);
				host_port_dma_pm0_wr_i <= 1'h0;
				go(1);
				note(2'h3, 15'h0000, 15'h0008, 2);
			end
			repeat (4) begin
				go(2);
				b = 1'($urandom);
				host_busy_i <= b;
				flag_out_i <= 1'($urandom);
				flag_dir_out_i <= 1'($urandom);
				note(2'h2, !s[2] ? 15'h0000 : s[3] ? {13'h0000, !b, 1'h0} : {13'h0000, 1'h1, b},
					bad ? 15'h0000 : 15'h0003, 2);
			end
			go(1);
			flag_dir_out_i <= 1'h1;
			flag_out_i <= b;
			go(6);
			note(2'h3, {9'h000, 1'h1, b, 4'h0}, 15'h0030, 1);
			repeat (12) begin
				go(1);
				ps = 4'($urandom % 8);
				ds = 4'($urandom % 9);
				pa = 14'($urandom);
				da = 14'($urandom);
				if (ps == 4'h3) ps = 4'h0;
				if (ds == 4'h3) ds = 4'h0;
				prog_window_sel_i <= ps;
				data_window_sel_i <= ds;
				prog_addr_i <= pa;
				data_addr_i <= da;
				pe = ps inside {4'h1, 4'h2} && pa >= 14'h2000;
				de = ds inside {4'h1, 4'h2} && da >= 14'h2000;
				note(2'h0, {pe, ps == 4'h2, pa[12:0]}, pe ? 15'h7FFF : 15'h4000, 2);
				note(2'h1, {de, ds == 4'h2, da[12:0]}, de ? 15'h7FFF : 15'h4000, 2);
			end
		end
		go(4);
		stop_test();
	end
endmodule : bmod_top_test
